// >>> common/rsqco_consts.svh
/*
  Timing counts and reset values for the reset sequencer.
  Assumes inclusion by bare name from the sequencer files.
*/
// Contract
// - Any reset returns peripheral registers to default and points the next fetch at address zero.
// - Reset defines only the program counter; other core registers stay undefined.
// - External reset is active low, asserts asynchronously and releases synchronised to the master clock.
// - The first fetch comes eighty master-clock cycles after the external reset pin rises.
// - A watchdog reset, when enabled, has the same effect as an external reset.
// - A watchdog reset leaves the latched boot width and tri-state mode unchanged.
// - External reset wins over a simultaneous watchdog reset request.
// - After reset every peripheral line is an input with its driver off; code: O_IO_INPUT_ONLY drops after reset unless in tri-state mode.
// - The clock output carries the master clock during and after reset until the line is reprogrammed; code: after reset it follows I_CLKOUT_AS_GPIO.
// - On external reset the boot width is the strap level held over the last ten cycles.
// - A high boot-width strap selects 8-bit boot memory on chip select zero, low selects 16-bit.
// - On external reset tri-state mode is entered if its strap was low over the last ten cycles.
`ifndef RSQCO_CONSTS_SVH
`define RSQCO_CONSTS_SVH
`define RSQCO_FETCH_DELAY 80
`define RSQCO_PIN_LATENCY 5
`define RSQCO_STRAP_CYCLES 10
`define RSQCO_RESET_PC 32'h0000_0000
`define RSQCO_BOOT_WIDTH_RST 1'b0
`define RSQCO_TRISTATE_RST 1'b0
`define RSQCO_WD_HOLD 4
`endif

// >>> common/rsqco_pkg.sv
/*
  Types for the reset sequencer.
  Assumes no other package.
*/
`default_nettype none
package rsqco_pkg;
  typedef enum logic [1:0] {
    RSQCO_ST_PIN,
    RSQCO_ST_WD,
    RSQCO_ST_DELAY,
    RSQCO_ST_RUN
  } rsqco_state_t;
endpackage
`default_nettype wire

// >>> rtl/rsqco_strap_window.sv
/*
  Strap sampler: tracks whether a synchronised strap level has stood
  unchanged for the last N cycles, reporting the steady level.
  Assumes the input is already synchronised to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rsqco_consts.svh"
module rsqco_strap_window #(
  parameter int N = `RSQCO_STRAP_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_level,
  output logic o_steady,
  output logic o_level
);
  logic [4:0] run_r;
  logic last_r;
  wire logic same = (i_level == last_r);
  wire logic full = (run_r >= 5'(N));
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      run_r <= 5'h00;
      last_r <= 1'b1;
    end else begin
      last_r <= i_level;
      if (!same)
        run_r <= 5'h01;
      else if (!full)
        run_r <= run_r + 5'h01;
    end
  end
  assign o_steady = full;
  assign o_level = last_r;
endmodule
`default_nettype wire

// >>> rtl/rsqco_reset_seq.sv
/*
  Reset sequencer with clock image output. Combines the external reset pin
  and the watchdog request, holds the core and peripherals in reset, counts
  the fetch delay, latches boot straps on pin resets only.
  The fetch count already allows for the pin synchroniser and output stage.
  Assumes straps and reset pin are asynchronous pins; watchdog request is
  from logic on the master clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rsqco_consts.svh"
module rsqco_reset_seq
  import rsqco_pkg::*;
#(
  parameter int FETCH_DELAY = `RSQCO_FETCH_DELAY,
  parameter int STRAP_CYCLES = `RSQCO_STRAP_CYCLES,
  parameter int WD_HOLD = `RSQCO_WD_HOLD
) (
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic I_EXT_RESET_N,
  input wire logic I_WD_RESET_REQ,
  input wire logic I_WD_RESET_EN,
  input wire logic I_BOOT_WIDTH_STRAP,
  input wire logic I_TRISTATE_STRAP_N,
  input wire logic I_CLKOUT_AS_GPIO,
  input wire logic I_CLKOUT_GPIO_VAL,
  output logic O_PERIPH_RESET,
  output logic O_CORE_RESET,
  output logic O_FETCH_ENABLE,
  output logic [31:0] O_RESET_PC,
  output logic O_BOOT_8BIT,
  output logic O_TRISTATE_MODE,
  output logic O_IO_INPUT_ONLY,
  output logic O_MASTER_CLK_OUT_SEL,
  output logic O_MASTER_CLK_OUT_GPIO,
  output logic O_WD_RESET_SEEN
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // reset pin: async assert
  wire logic pin_async_rst = I_RESET | ~I_EXT_RESET_N;
  logic [2:0] ext_reset_n_sync_r;
  always_ff @(posedge I_MCLK or posedge pin_async_rst) begin
    if (pin_async_rst)
      ext_reset_n_sync_r <= 3'h0;
    else
      ext_reset_n_sync_r <= {ext_reset_n_sync_r[1:0], 1'b1};
  end
  // release only once second and third stages agree
  wire logic pin_released = ext_reset_n_sync_r[1] & ext_reset_n_sync_r[2];

  logic [2:0] bw_sync_r;
  logic [2:0] tri_sync_r;
  logic bw_level_r;
  logic tri_level_r;
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      bw_sync_r <= 3'h0;
      tri_sync_r <= 3'h7;
      bw_level_r <= 1'b0;
      tri_level_r <= 1'b1;
    end else begin
      bw_sync_r <= {bw_sync_r[1:0], I_BOOT_WIDTH_STRAP};
      tri_sync_r <= {tri_sync_r[1:0], I_TRISTATE_STRAP_N};
      if (bw_sync_r[1] == bw_sync_r[2])
        bw_level_r <= bw_sync_r[2];
      if (tri_sync_r[1] == tri_sync_r[2])
        tri_level_r <= tri_sync_r[2];
    end
  end

  // ------------------------------------------------------------
  // strap windows
  // ------------------------------------------------------------
  logic bw_steady;
  logic bw_val;
  logic tri_steady;
  logic tri_val;
  rsqco_strap_window #(.N(STRAP_CYCLES)) u_bw_win (
    .i_clk(I_MCLK),
    .i_rst(I_RESET),
    .i_level(bw_level_r),
    .o_steady(bw_steady),
    .o_level(bw_val)
  );
  rsqco_strap_window #(.N(STRAP_CYCLES)) u_tri_win (
    .i_clk(I_MCLK),
    .i_rst(I_RESET),
    .i_level(tri_level_r),
    .o_steady(tri_steady),
    .o_level(tri_val)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  rsqco_state_t state_r;
  rsqco_state_t state_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic boot_8bit_r;
  logic tristate_r;
  logic pin_rel_d_r;
  logic wd_seen_r;

  wire logic wd_fire = I_WD_RESET_REQ & I_WD_RESET_EN;
  wire logic pin_rise = pin_released & ~pin_rel_d_r;
  // counter sits on the last of n cycles
  function automatic logic cnt_last(input logic [7:0] c, input int n);
    cnt_last = (c == 8'(n - 1));
  endfunction

  // sync, state and output stages eat part of the fetch delay
  wire logic delay_done = cnt_last(cnt_r, FETCH_DELAY - `RSQCO_PIN_LATENCY);
  wire logic hold_done = cnt_last(cnt_r, WD_HOLD);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      RSQCO_ST_PIN: begin
        cnt_nxt = 8'h00;
        if (pin_rise)
          state_nxt = RSQCO_ST_DELAY;
      end
      RSQCO_ST_WD: begin
        cnt_nxt = cnt_r + 8'h01;
        if (hold_done) begin
          state_nxt = RSQCO_ST_DELAY;
          cnt_nxt = 8'h00;
        end
      end
      RSQCO_ST_DELAY: begin
        cnt_nxt = cnt_r + 8'h01;
        if (delay_done)
          state_nxt = RSQCO_ST_RUN;
      end
      RSQCO_ST_RUN: begin
        cnt_nxt = 8'h00;
      end
      default: begin
        state_nxt = RSQCO_ST_PIN;
        cnt_nxt = 8'h00;
      end
    endcase
    // watchdog restarts sequence, pin held state absorbs it
    if (wd_fire && state_r != RSQCO_ST_PIN) begin
      state_nxt = RSQCO_ST_WD;
      cnt_nxt = 8'h00;
    end
  end

  // pin reset forces pin state asynchronously
  always_ff @(posedge I_MCLK or posedge pin_async_rst) begin
    if (pin_async_rst) begin
      state_r <= RSQCO_ST_PIN;
      cnt_r <= 8'h00;
      pin_rel_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pin_rel_d_r <= pin_released;
    end
  end

  wire logic strap_take = (state_r == RSQCO_ST_PIN) && pin_rise;
  wire logic boot_cap = bw_steady ? bw_val : bw_level_r;
  wire logic tri_cap = tri_steady & ~tri_val;

  // straps captured at pin release only, never on watchdog
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      boot_8bit_r <= `RSQCO_BOOT_WIDTH_RST;
      tristate_r <= `RSQCO_TRISTATE_RST;
      wd_seen_r <= 1'b0;
    end else begin
      if (strap_take) begin
        boot_8bit_r <= boot_cap;
        tristate_r <= tri_cap;
        wd_seen_r <= 1'b0;
      end else if (state_r == RSQCO_ST_WD) begin
        wd_seen_r <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  wire logic in_reset = (state_r != RSQCO_ST_RUN);
  wire logic io_off_nxt = in_reset | tristate_r;
  wire logic clk_sel_nxt = in_reset | ~I_CLKOUT_AS_GPIO;

  // pin low reaches the outputs without waiting for a clock
  always_ff @(posedge I_MCLK or posedge pin_async_rst) begin
    if (pin_async_rst) begin
      O_PERIPH_RESET <= 1'b1;
      O_CORE_RESET <= 1'b1;
      O_FETCH_ENABLE <= 1'b0;
      O_RESET_PC <= `RSQCO_RESET_PC;
      O_IO_INPUT_ONLY <= 1'b1;
      O_MASTER_CLK_OUT_SEL <= 1'b1;
      O_MASTER_CLK_OUT_GPIO <= 1'b0;
    end else begin
      O_PERIPH_RESET <= in_reset;
      O_CORE_RESET <= in_reset;
      O_FETCH_ENABLE <= ~in_reset;
      O_RESET_PC <= `RSQCO_RESET_PC;
      O_IO_INPUT_ONLY <= io_off_nxt;
      O_MASTER_CLK_OUT_SEL <= clk_sel_nxt;
      O_MASTER_CLK_OUT_GPIO <= I_CLKOUT_GPIO_VAL;
    end
  end
  assign O_BOOT_8BIT = boot_8bit_r;
  assign O_TRISTATE_MODE = tristate_r;
  assign O_WD_RESET_SEEN = wd_seen_r;
endmodule
`default_nettype wire

// >>> dv/rsqco_reset_seq_props.sv
/*
  Checker for the reset sequencer ports.
  Assumes it is bound to rsqco_reset_seq on one master clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rsqco_reset_seq_props #(
  parameter int FETCH_DELAY = 80
) (
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic I_EXT_RESET_N,
  input wire logic I_WD_RESET_REQ,
  input wire logic I_WD_RESET_EN,
  input wire logic I_CLKOUT_AS_GPIO,
  input wire logic O_CORE_RESET,
  input wire logic O_FETCH_ENABLE,
  input wire logic [31:0] O_RESET_PC,
  input wire logic O_BOOT_8BIT,
  input wire logic O_TRISTATE_MODE,
  input wire logic O_IO_INPUT_ONLY,
  input wire logic O_MASTER_CLK_OUT_SEL,
  input wire logic O_WD_RESET_SEEN
);
  localparam int FD_GAP = FETCH_DELAY - 8;
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  a_pc_zero: assert property (O_RESET_PC == 32'h0000_0000)
    else $error("fetch address not zero");
  a_pin_resets: assert property (!I_EXT_RESET_N |=> O_CORE_RESET && !O_FETCH_ENABLE)
    else $error("pin reset not applied");
  a_fetch_delay: assert property ($rose(I_EXT_RESET_N) |->
    (!O_FETCH_ENABLE)[*8] ##FD_GAP !O_FETCH_ENABLE ##1 O_FETCH_ENABLE)
    else $error("first fetch timing wrong");
  a_io_inputs: assert property (O_CORE_RESET |-> O_IO_INPUT_ONLY)
    else $error("io driven during reset");
  a_clk_image: assert property (!I_CLKOUT_AS_GPIO ##1 !I_CLKOUT_AS_GPIO |-> O_MASTER_CLK_OUT_SEL)
    else $error("clock image not selected");
  a_straps_kept: assert property (I_EXT_RESET_N[*8] |->
    $stable(O_BOOT_8BIT) && $stable(O_TRISTATE_MODE))
    else $error("straps changed without pin reset");
  a_wd_resets: assert property (I_WD_RESET_REQ && I_WD_RESET_EN && !O_CORE_RESET |->
    ##[1:3] O_CORE_RESET)
    else $error("watchdog reset missed");
  a_wd_disabled: assert property (I_WD_RESET_REQ && !I_WD_RESET_EN && !O_CORE_RESET &&
    I_EXT_RESET_N |=> !O_CORE_RESET)
    else $error("disabled watchdog reset");
  a_pin_priority: assert property (!I_EXT_RESET_N ##1 !I_EXT_RESET_N |-> !$rose(O_WD_RESET_SEEN))
    else $error("watchdog beat pin reset");
endmodule
bind rsqco_reset_seq rsqco_reset_seq_props #(.FETCH_DELAY(FETCH_DELAY)) i_rsqco_reset_seq_props (
  .I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_EXT_RESET_N(I_EXT_RESET_N),
  .I_WD_RESET_REQ(I_WD_RESET_REQ), .I_WD_RESET_EN(I_WD_RESET_EN),
  .I_CLKOUT_AS_GPIO(I_CLKOUT_AS_GPIO), .O_CORE_RESET(O_CORE_RESET),
  .O_FETCH_ENABLE(O_FETCH_ENABLE), .O_RESET_PC(O_RESET_PC), .O_BOOT_8BIT(O_BOOT_8BIT),
  .O_TRISTATE_MODE(O_TRISTATE_MODE), .O_IO_INPUT_ONLY(O_IO_INPUT_ONLY),
  .O_MASTER_CLK_OUT_SEL(O_MASTER_CLK_OUT_SEL), .O_WD_RESET_SEEN(O_WD_RESET_SEEN));
`default_nettype wire

// >>> dv/rsqco_board_model.sv
/*
  Board reset circuit: pulls the reset pin low with straps set.
  Assumes the master clock already runs when a pulse is requested.
*/
`timescale 1ns/1ps
`default_nettype none
module rsqco_board_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_boot,
  input wire logic i_tri_n,
  output logic o_rst_n,
  output logic o_boot,
  output logic o_tri_n
);
  int cnt = 0;
  initial begin
    o_rst_n = 1'b0;
    o_boot = 1'b0;
    o_tri_n = 1'b1;
  end
  always @(posedge i_clk) begin
    if (i_go && cnt == 0) begin
      cnt <= 12;
      o_rst_n <= 1'b0;
      o_boot <= i_boot;
      o_tri_n <= i_tri_n;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      o_rst_n <= 1'b1;
      // straps free after release
      o_boot <= ~o_boot;
      o_tri_n <= ~o_tri_n;
    end
  end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
/*
  Testbench for the reset sequencer.
  Assumes the board model and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int FD = 8;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, bs = 1'b0, tn = 1'b1;
  logic wd_req = 1'b0, wd_en = 1'b0, g_sel = 1'b0, g_val = 1'b0, eb, et;
  logic pin_n, boot_s, tri_s, prst, core_rst, fetch, boot8, tri_m, io_in, sel, g_out, wd_seen;
  logic [31:0] pc;
  int mismatches = 0, tests_run = 0, cycles = 0;
  rsqco_board_model i_rsqco_board_model (.i_clk(clk), .i_go(go), .i_boot(bs), .i_tri_n(tn),
    .o_rst_n(pin_n), .o_boot(boot_s), .o_tri_n(tri_s));
  rsqco_reset_seq #(.FETCH_DELAY(FD)) i_rsqco_reset_seq (.I_MCLK(clk), .I_RESET(rst),
    .I_EXT_RESET_N(pin_n), .I_WD_RESET_REQ(wd_req), .I_WD_RESET_EN(wd_en),
    .I_BOOT_WIDTH_STRAP(boot_s), .I_TRISTATE_STRAP_N(tri_s), .I_CLKOUT_AS_GPIO(g_sel),
    .I_CLKOUT_GPIO_VAL(g_val), .O_PERIPH_RESET(prst), .O_CORE_RESET(core_rst),
    .O_FETCH_ENABLE(fetch), .O_RESET_PC(pc), .O_BOOT_8BIT(boot8), .O_TRISTATE_MODE(tri_m),
    .O_IO_INPUT_ONLY(io_in), .O_MASTER_CLK_OUT_SEL(sel), .O_MASTER_CLK_OUT_GPIO(g_out),
    .O_WD_RESET_SEEN(wd_seen));
  initial forever #25 clk = ~clk;
  task automatic stop_test;
    $display("tests %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      stop_test;
    end
  end
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic wait_fetch(output int n);
    n = 0;
    while (fetch !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask
  // pin reset, optionally with a watchdog request at the same time
  task automatic t_pin(input logic b, input logic t, input logic w);
    int n;
    go = 1'b1; bs = b; tn = t; wd_en = w; wd_req = w;
    repeat (3) @(negedge clk);
    go = 1'b0;
    check(core_rst === 1'b1 && prst === 1'b1 && io_in === 1'b1, "pin reset");
    check(sel === 1'b1, "clock image in reset");
    while (pin_n !== 1'b1) @(negedge clk);
    wd_req = 1'b0;
    wait_fetch(n);
    eb = b; et = ~t;
    check(n == FD, "fetch delay");
    check(boot8 === eb && tri_m === et, "strap latch");
    check(pc === 32'h0000_0000 && core_rst === 1'b0, "fetch start");
    check(wd_seen === 1'b0, "pin priority");
    $display("pin reset test done");
  endtask
  task automatic t_wd(input logic en);
    int n;
    wd_en = en; wd_req = 1'b1;
    @(negedge clk);
    wd_req = 1'b0;
    repeat (2) @(negedge clk);
    check(core_rst === en && wd_seen === en && io_in === (en | et), "watchdog reset");
    wait_fetch(n);
    check(boot8 === eb && tri_m === et && fetch === 1'b1, "straps kept");
    $display("watchdog test done");
  endtask
  task automatic t_clkout;
    g_sel = 1'b1; g_val = 1'b1;
    repeat (3) @(negedge clk);
    check(sel === 1'b0 && g_out === 1'b1, "clock pin as io");
    t_pin(1'b0, 1'b1, 1'b0);
    g_sel = 1'b0;
    repeat (3) @(negedge clk);
    check(sel === 1'b1, "clock image back");
    $display("clock out test done");
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) t_pin(i[0], i[1], 1'b0);
    t_wd(1'b0);
    t_wd(1'b1);
    t_pin(1'b1, 1'b1, 1'b1);
    t_clkout;
    stop_test;
  end
endmodule
`default_nettype wire
